// file: cso_defs.svh
`ifndef CSO_DEFS_SVH
`define CSO_DEFS_SVH

// Register byte offsets
`define CSO_OFF_CTRL 8'h00
`define CSO_OFF_DST 8'h04
`define CSO_OFF_SRC 8'h08
`define CSO_OFF_FLAGS 8'h0C
`define CSO_OFF_GUARD 8'h10
`define CSO_OFF_STATUS 8'h14
`define CSO_OFF_RESULT 8'h18

// Control register fields
`define CSO_CTRL_START_BIT 8

// Flag register field positions
`define CSO_FLAG_C_BIT 7
`define CSO_FLAG_Z_BIT 6
`define CSO_FLAG_S_BIT 5
`define CSO_FLAG_V_BIT 4

// Status register field positions
`define CSO_ST_BUSY_BIT 0
`define CSO_ST_HALTED_BIT 1
`define CSO_ST_REDIR_BIT 2
`define CSO_ST_ILLEGAL_BIT 3
`define CSO_ST_DONE_BIT 4
`define CSO_ST_FORM_LSB 5
`define CSO_ST_BYTES_LSB 8
`define CSO_ST_CYCLES_LSB 12

// Reset values and guard unlock value
`define CSO_RST_BYTE 8'h00
`define CSO_RST_GUARD 8'h00
`define CSO_GUARD_UNLOCK 8'hA5

// Opcode encodings
`define CSO_OP_SET_CARRY 8'hDF
`define CSO_OP_HALT 8'h7F
`define CSO_OP_SHIFT_R 8'hD0
`define CSO_OP_SHIFT_IR 8'hD1
`define CSO_HI_SUB 4'h2
`define CSO_HI_TEST_INV 4'h6
`define CSO_HI_TEST 4'h7
`define CSO_LO_WW 4'h2
`define CSO_LO_WIND 4'h3
`define CSO_LO_RR 4'h4
`define CSO_LO_RIND 4'h5
`define CSO_LO_RIMM 4'h6
`define CSO_OP_SUB_WW {`CSO_HI_SUB, `CSO_LO_WW}
`define CSO_OP_SUB_RR {`CSO_HI_SUB, `CSO_LO_RR}

// Lengths and cycle counts
`define CSO_CYC_SHORT 3'h4
`define CSO_CYC_LONG 3'h6
`define CSO_CYC_ILLEGAL 3'h1
`define CSO_LEN_ONE 2'h1
`define CSO_LEN_TWO 2'h2
`define CSO_LEN_THREE 2'h3

`endif

// file: cso_pkg.sv
`default_nettype none

package cso_pkg;

    typedef enum logic [1:0] {PH_IDLE, PH_EXEC, PH_HALTED} cso_phase_t;

    typedef enum logic [1:0] {FORM_NONE, FORM_REG, FORM_INDIRECT, FORM_IMMEDIATE} cso_form_t;

    typedef enum logic [2:0] {
        CLS_ILLEGAL, CLS_SET_CARRY, CLS_SHIFT, CLS_HALT, CLS_SUB, CLS_TEST_INV, CLS_TEST
    } cso_class_t;

    typedef struct packed {
        logic c;
        logic z;
        logic s;
        logic v;
    } cso_flags_t;

    typedef struct packed {
        cso_phase_t phase;
        logic [2:0] cnt;
        logic [7:0] opcode;
        logic [7:0] dst;
        logic [7:0] src;
        cso_flags_t flags;
        logic [7:0] guard;
        logic [7:0] result;
        logic redirSticky;
        logic illegalSticky;
        logic doneSticky;
        logic pcRedirect;
        logic [31:0] rdata;
    } cso_state_t;

endpackage

`default_nettype wire

// file: cso_alu_if.sv
`timescale 1ns/100ps
`default_nettype none

interface cso_alu_if;
    logic [7:0] opcode;
    logic [7:0] dstVal;
    logic [7:0] srcVal;
    cso_pkg::cso_flags_t flagsIn;
    logic [7:0] result;
    cso_pkg::cso_flags_t flagsOut;
    logic writeBack;
    cso_pkg::cso_class_t opClass;
    cso_pkg::cso_form_t srcForm;
    logic [1:0] byteLen;
    logic [2:0] cycleCnt;

    modport core (
        output opcode, dstVal, srcVal, flagsIn,
        input result, flagsOut, writeBack, opClass, srcForm, byteLen, cycleCnt
    );
    modport alu (
        input opcode, dstVal, srcVal, flagsIn,
        output result, flagsOut, writeBack, opClass, srcForm, byteLen, cycleCnt
    );
endinterface

`default_nettype wire

// file: cso_alu.sv
`timescale 1ns/100ps
`default_nettype none
`include "cso_defs.svh"

module cso_alu (
    cso_alu_if.alu aluBus // Operands in, result and decode out
);
    logic [8:0] sum9;
    logic [3:0] hi;
    logic [3:0] lo;

    // Decode, then evaluate the selected operation
    always_comb begin
        hi = aluBus.opcode[7:4];
        lo = aluBus.opcode[3:0];
        // Difference built by adding the two's complement of the source
        sum9 = {1'b0, aluBus.dstVal} + {1'b0, ~aluBus.srcVal} + 9'h001;
        aluBus.opClass = cso_pkg::CLS_ILLEGAL;
        aluBus.srcForm = cso_pkg::FORM_NONE;
        aluBus.byteLen = `CSO_LEN_ONE;
        aluBus.cycleCnt = `CSO_CYC_ILLEGAL;
        aluBus.result = aluBus.dstVal;
        aluBus.flagsOut = aluBus.flagsIn;
        aluBus.writeBack = 1'b0;
        if (aluBus.opcode == `CSO_OP_SET_CARRY) begin
            aluBus.opClass = cso_pkg::CLS_SET_CARRY;
            aluBus.cycleCnt = `CSO_CYC_SHORT;
        end else if (aluBus.opcode == `CSO_OP_HALT) begin
            aluBus.opClass = cso_pkg::CLS_HALT;
            aluBus.cycleCnt = `CSO_CYC_SHORT;
        end else if (aluBus.opcode == `CSO_OP_SHIFT_R || aluBus.opcode == `CSO_OP_SHIFT_IR) begin
            aluBus.opClass = cso_pkg::CLS_SHIFT;
            aluBus.byteLen = `CSO_LEN_TWO;
            aluBus.cycleCnt = `CSO_CYC_SHORT;
            aluBus.srcForm = (aluBus.opcode == `CSO_OP_SHIFT_R) ?
                cso_pkg::FORM_REG : cso_pkg::FORM_INDIRECT;
        end else if ((hi == `CSO_HI_SUB || hi == `CSO_HI_TEST_INV || hi == `CSO_HI_TEST)
                && lo >= `CSO_LO_WW && lo <= `CSO_LO_RIMM) begin
            // Same five operand forms for all three two-operand groups
            aluBus.opClass = (hi == `CSO_HI_SUB) ? cso_pkg::CLS_SUB :
                (hi == `CSO_HI_TEST_INV) ? cso_pkg::CLS_TEST_INV : cso_pkg::CLS_TEST;
            aluBus.byteLen = (lo <= `CSO_LO_WIND) ? `CSO_LEN_TWO : `CSO_LEN_THREE;
            aluBus.cycleCnt = (lo == `CSO_LO_WW) ? `CSO_CYC_SHORT : `CSO_CYC_LONG;
            aluBus.srcForm = (lo == `CSO_LO_RIMM) ? cso_pkg::FORM_IMMEDIATE :
                (lo == `CSO_LO_WIND || lo == `CSO_LO_RIND) ?
                cso_pkg::FORM_INDIRECT : cso_pkg::FORM_REG;
        end
        // Result and flags per class
        unique case (aluBus.opClass)
            cso_pkg::CLS_SET_CARRY: begin
                aluBus.flagsOut.c = 1'b1;
            end
            cso_pkg::CLS_SHIFT: begin
                aluBus.result = {aluBus.dstVal[7], aluBus.dstVal[7:1]};
                aluBus.writeBack = 1'b1;
                aluBus.flagsOut.c = aluBus.dstVal[0];
                aluBus.flagsOut.z = ({aluBus.dstVal[7], aluBus.dstVal[7:1]} == 8'h00);
                aluBus.flagsOut.s = aluBus.dstVal[7];
                aluBus.flagsOut.v = 1'b0;
            end
            cso_pkg::CLS_SUB: begin
                aluBus.result = sum9[7:0];
                aluBus.writeBack = 1'b1;
                aluBus.flagsOut.c = ~sum9[8];
                aluBus.flagsOut.z = (sum9[7:0] == 8'h00);
                aluBus.flagsOut.s = sum9[7];
                aluBus.flagsOut.v = (aluBus.dstVal[7] != aluBus.srcVal[7])
                    && (sum9[7] == aluBus.srcVal[7]);
            end
            cso_pkg::CLS_TEST_INV: begin
                aluBus.result = ~aluBus.dstVal & aluBus.srcVal;
                aluBus.flagsOut.z = ((~aluBus.dstVal & aluBus.srcVal) == 8'h00);
                aluBus.flagsOut.s = ~aluBus.dstVal[7] & aluBus.srcVal[7];
                aluBus.flagsOut.v = 1'b0;
            end
            cso_pkg::CLS_TEST: begin
                aluBus.result = aluBus.dstVal & aluBus.srcVal;
                aluBus.flagsOut.z = ((aluBus.dstVal & aluBus.srcVal) == 8'h00);
                aluBus.flagsOut.s = aluBus.dstVal[7] & aluBus.srcVal[7];
                aluBus.flagsOut.v = 1'b0;
            end
            default: begin
                // Halt and unknown opcodes leave operands and flags alone
                aluBus.writeBack = 1'b0;
            end
        endcase
    end
endmodule

`default_nettype wire

// file: cso_shift_sub_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "cso_defs.svh"

//Contract
//- Set-carry opcode takes one byte, four cycles, forces carry, keeps other flags.
//- Arithmetic right shift moves bits down, keeps bit 7, old bit 0 to carry.
//- After shift: carry is shifted-out bit, zero and sign from result, overflow cleared.
//- Shift takes two bytes and four cycles, direct or indirect register form.
//- Halt opcode stops CPU and system clocks, keeps all state, changes no flags.
//- Halted mode ends only on external reset or external interrupt input.
//- Halt without unlock value in guard register redirects program counter to reset.
//- Subtract writes destination minus source, source kept, via two's complement add.
//- Subtract flags: borrow, zero, negative, overflow on sign rule with source.
//- Subtract has five forms: 2 bytes 4 or 6 cycles, 3 bytes 6 cycles.
//- Inverted mask test ANDs inverted destination with mask, stores nothing.
//- Inverted mask test: carry kept, zero and sign from result, overflow cleared.
//- Mask test ANDs destination with mask, stores nothing, same five forms.
//- Mask test: carry kept, zero and sign from result, overflow cleared.
module cso_shift_sub_test #(
    parameter int ADDR_W = 8 // APB address width
) (
    input wire logic ref_clk, // 10 MHz core clock
    input wire logic arst_n, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction, high for write
    input wire logic [ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready, never stalls
    output logic pslverr, // APB error on unmapped address
    input wire logic extIntr, // External interrupt, wakes halted mode
    output logic cpuClkStop, // CPU clock held off
    output logic sysClkStop, // System clock held off
    output logic haltedMode, // Low-power halted mode active
    output logic pcRedirect, // One-cycle pulse: jump to reset address
    output logic busy // Instruction in progress
);
    localparam cso_pkg::cso_state_t ST_RESET = '{
        phase: cso_pkg::PH_IDLE,
        cnt: 3'h0,
        opcode: `CSO_RST_BYTE,
        dst: `CSO_RST_BYTE,
        src: `CSO_RST_BYTE,
        flags: 4'h0,
        guard: `CSO_RST_GUARD,
        result: `CSO_RST_BYTE,
        redirSticky: 1'b0,
        illegalSticky: 1'b0,
        doneSticky: 1'b0,
        pcRedirect: 1'b0,
        rdata: 32'h00000000
    };

    cso_pkg::cso_state_t st_reg;
    cso_pkg::cso_state_t st_next;
    cso_alu_if aluBus();
    logic setupPh;
    logic wrTake;
    logic addrHit;
    logic startTake;
    logic commitNow;
    logic [7:0] offs;
    logic [31:0] statusWord;
    logic [31:0] readWord;

    // Operands come straight from the held state
    assign aluBus.opcode = st_reg.opcode;
    assign aluBus.dstVal = st_reg.dst;
    assign aluBus.srcVal = st_reg.src;
    assign aluBus.flagsIn = st_reg.flags;

    cso_alu u_alu (
        .aluBus(aluBus.alu)
    );

    // APB decode; zero wait states keep the core simple
    assign offs = 8'(paddr);
    assign setupPh = psel && !penable;
    assign wrTake = psel && penable && pwrite && addrHit;
    assign addrHit = (offs == `CSO_OFF_CTRL) || (offs == `CSO_OFF_DST)
        || (offs == `CSO_OFF_SRC) || (offs == `CSO_OFF_FLAGS)
        || (offs == `CSO_OFF_GUARD) || (offs == `CSO_OFF_STATUS)
        || (offs == `CSO_OFF_RESULT);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addrHit;
    assign prdata = st_reg.rdata;

    // Start only from idle; a start while busy or halted is dropped
    assign startTake = wrTake && (offs == `CSO_OFF_CTRL) && pwdata[`CSO_CTRL_START_BIT]
        && (st_reg.phase == cso_pkg::PH_IDLE);
    assign commitNow = (st_reg.phase == cso_pkg::PH_EXEC)
        && (st_reg.cnt == aluBus.cycleCnt - 3'h1);

    // Status word assembled from live state
    always_comb begin
        statusWord = 32'h00000000;
        statusWord[`CSO_ST_BUSY_BIT] = (st_reg.phase == cso_pkg::PH_EXEC);
        statusWord[`CSO_ST_HALTED_BIT] = (st_reg.phase == cso_pkg::PH_HALTED);
        statusWord[`CSO_ST_REDIR_BIT] = st_reg.redirSticky;
        statusWord[`CSO_ST_ILLEGAL_BIT] = st_reg.illegalSticky;
        statusWord[`CSO_ST_DONE_BIT] = st_reg.doneSticky;
        statusWord[`CSO_ST_FORM_LSB +: 2] = aluBus.srcForm;
        statusWord[`CSO_ST_BYTES_LSB +: 2] = aluBus.byteLen;
        statusWord[`CSO_ST_CYCLES_LSB +: 3] = aluBus.cycleCnt;
    end

    // Read mux; captured in the setup cycle so prdata is a flop
    always_comb begin
        readWord = 32'h00000000;
        unique case (offs)
            `CSO_OFF_CTRL: readWord[7:0] = st_reg.opcode;
            `CSO_OFF_DST: readWord[7:0] = st_reg.dst;
            `CSO_OFF_SRC: readWord[7:0] = st_reg.src;
            `CSO_OFF_FLAGS: begin
                readWord[`CSO_FLAG_C_BIT] = st_reg.flags.c;
                readWord[`CSO_FLAG_Z_BIT] = st_reg.flags.z;
                readWord[`CSO_FLAG_S_BIT] = st_reg.flags.s;
                readWord[`CSO_FLAG_V_BIT] = st_reg.flags.v;
            end
            `CSO_OFF_GUARD: readWord[7:0] = st_reg.guard;
            `CSO_OFF_STATUS: readWord = statusWord;
            `CSO_OFF_RESULT: readWord[7:0] = st_reg.result;
            default: readWord = 32'h00000000;
        endcase
    end

    // Next-state logic for the whole block
    always_comb begin
        st_next = st_reg;
        st_next.pcRedirect = 1'b0;
        if (setupPh && !pwrite) begin
            st_next.rdata = readWord;
        end
        // Software writes; operands and flags are frozen while executing
        if (wrTake && st_reg.phase == cso_pkg::PH_IDLE) begin
            unique case (offs)
                `CSO_OFF_CTRL: st_next.opcode = pwdata[7:0];
                `CSO_OFF_DST: st_next.dst = pwdata[7:0];
                `CSO_OFF_SRC: st_next.src = pwdata[7:0];
                `CSO_OFF_FLAGS: begin
                    st_next.flags.c = pwdata[`CSO_FLAG_C_BIT];
                    st_next.flags.z = pwdata[`CSO_FLAG_Z_BIT];
                    st_next.flags.s = pwdata[`CSO_FLAG_S_BIT];
                    st_next.flags.v = pwdata[`CSO_FLAG_V_BIT];
                end
                `CSO_OFF_GUARD: st_next.guard = pwdata[7:0];
                default: st_next.guard = st_reg.guard;
            endcase
        end
        // Sticky status bits clear on write-one; a same-cycle set below wins
        if (wrTake && offs == `CSO_OFF_STATUS) begin
            if (pwdata[`CSO_ST_REDIR_BIT]) st_next.redirSticky = 1'b0;
            if (pwdata[`CSO_ST_ILLEGAL_BIT]) st_next.illegalSticky = 1'b0;
            if (pwdata[`CSO_ST_DONE_BIT]) st_next.doneSticky = 1'b0;
        end
        unique case (st_reg.phase)
            cso_pkg::PH_IDLE: begin
                if (startTake) begin
                    st_next.phase = cso_pkg::PH_EXEC;
                    st_next.cnt = 3'h0;
                end
            end
            cso_pkg::PH_EXEC: begin
                st_next.cnt = st_reg.cnt + 3'h1;
                if (commitNow) begin
                    // Result and flags land on the same edge
                    st_next.phase = cso_pkg::PH_IDLE;
                    st_next.cnt = 3'h0;
                    st_next.flags = aluBus.flagsOut;
                    st_next.result = aluBus.result;
                    st_next.doneSticky = 1'b1;
                    if (aluBus.writeBack) begin
                        st_next.dst = aluBus.result;
                    end
                    if (aluBus.opClass == cso_pkg::CLS_ILLEGAL) begin
                        st_next.illegalSticky = 1'b1;
                    end
                    if (aluBus.opClass == cso_pkg::CLS_HALT) begin
                        if (st_reg.guard == `CSO_GUARD_UNLOCK) begin
                            st_next.phase = cso_pkg::PH_HALTED;
                        end else begin
                            // Guard protects against a stray halt opcode
                            st_next.pcRedirect = 1'b1;
                            st_next.redirSticky = 1'b1;
                        end
                    end
                end
            end
            cso_pkg::PH_HALTED: begin
                // Reset wakes through arst_n; interrupt wakes here
                if (extIntr) begin
                    st_next.phase = cso_pkg::PH_IDLE;
                end
            end
        endcase
    end

    // Single state register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from state
    assign haltedMode = (st_reg.phase == cso_pkg::PH_HALTED);
    assign cpuClkStop = haltedMode;
    assign sysClkStop = haltedMode;
    assign pcRedirect = st_reg.pcRedirect;
    assign busy = (st_reg.phase == cso_pkg::PH_EXEC);

    // Checks on the committed behaviour
    default clocking cbMain @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    sequence seqCommitOf(logic [7:0] op);
        commitNow && st_reg.opcode == op;
    endsequence

    sequence seqStartOf(logic [7:0] op);
        startTake && pwdata[7:0] == op;
    endsequence

    AST_SET_CARRY: assert property (seqCommitOf(`CSO_OP_SET_CARRY) |=> st_reg.flags.c
        && st_reg.flags.z == $past(st_reg.flags.z) && st_reg.flags.s == $past(st_reg.flags.s)
        && st_reg.flags.v == $past(st_reg.flags.v))
        else $error("set carry changed the wrong flags");

    AST_SET_CARRY_LEN: assert property (seqStartOf(`CSO_OP_SET_CARRY) |=> busy[*4] ##1 !busy)
        else $error("set carry did not take four cycles");

    AST_SHIFT_RESULT: assert property (commitNow && aluBus.opClass == cso_pkg::CLS_SHIFT
        |=> st_reg.dst == {$past(st_reg.dst[7]), $past(st_reg.dst[7:1])}
        && st_reg.flags.c == $past(st_reg.dst[0]))
        else $error("shift result or carry wrong");

    AST_SHIFT_FLAGS: assert property (commitNow && aluBus.opClass == cso_pkg::CLS_SHIFT
        |=> !st_reg.flags.v && st_reg.flags.z == (st_reg.dst == 8'h00)
        && st_reg.flags.s == st_reg.dst[7])
        else $error("shift flags wrong");

    AST_SHIFT_LEN: assert property (seqStartOf(`CSO_OP_SHIFT_IR) |=> busy[*4] ##1 !busy)
        else $error("shift did not take four cycles");

    AST_HALT_ENTER: assert property (commitNow && aluBus.opClass == cso_pkg::CLS_HALT
        && st_reg.guard == `CSO_GUARD_UNLOCK
        |=> cpuClkStop && sysClkStop && st_reg.flags == $past(st_reg.flags)
        && st_reg.dst == $past(st_reg.dst))
        else $error("halt entry wrong");

    AST_HALT_HOLD: assert property (haltedMode && !extIntr |=> haltedMode)
        else $error("halted mode left without a wake source");

    AST_HALT_WAKE: assert property (haltedMode && extIntr |=> !haltedMode && !cpuClkStop)
        else $error("interrupt did not wake halted mode");

    AST_REDIRECT: assert property (commitNow && aluBus.opClass == cso_pkg::CLS_HALT
        && st_reg.guard != `CSO_GUARD_UNLOCK |=> pcRedirect && !haltedMode ##1 !pcRedirect)
        else $error("locked halt did not redirect");

    AST_SUB_VALUE: assert property (commitNow && aluBus.opClass == cso_pkg::CLS_SUB
        |=> st_reg.dst == 8'($past(st_reg.dst) - $past(st_reg.src))
        && st_reg.src == $past(st_reg.src))
        else $error("subtract result wrong");

    AST_SUB_FLAGS: assert property (commitNow && aluBus.opClass == cso_pkg::CLS_SUB
        |=> st_reg.flags.c == ($past(st_reg.src) > $past(st_reg.dst))
        && st_reg.flags.z == (st_reg.dst == 8'h00) && st_reg.flags.s == st_reg.dst[7])
        else $error("subtract flags wrong");

    AST_SUB_LEN_SHORT: assert property (seqStartOf(`CSO_OP_SUB_WW) |=> busy[*4] ##1 !busy)
        else $error("short subtract length wrong");

    AST_SUB_LEN_LONG: assert property (seqStartOf(`CSO_OP_SUB_RR) |=> busy[*6] ##1 !busy)
        else $error("long subtract length wrong");

    AST_TEST_INV: assert property (commitNow && aluBus.opClass == cso_pkg::CLS_TEST_INV
        |=> $stable(st_reg.dst) && st_reg.flags.c == $past(st_reg.flags.c) && !st_reg.flags.v
        && st_reg.flags.z == ((~$past(st_reg.dst) & $past(st_reg.src)) == 8'h00))
        else $error("inverted mask test wrong");

    AST_TEST: assert property (commitNow && aluBus.opClass == cso_pkg::CLS_TEST
        |=> $stable(st_reg.dst) && st_reg.flags.c == $past(st_reg.flags.c) && !st_reg.flags.v
        && st_reg.flags.z == (($past(st_reg.dst) & $past(st_reg.src)) == 8'h00))
        else $error("mask test wrong");

    AST_FROZEN_EXEC: assert property (busy && !commitNow
        |=> $stable(st_reg.dst) && $stable(st_reg.flags))
        else $error("operands moved before completion");

    AST_SHIFT_LEN_DIRECT: assert property (seqStartOf(`CSO_OP_SHIFT_R) |=> busy[*4] ##1 !busy)
        else $error("direct shift did not take four cycles");

    // Overflow checked apart so a sign slip shows on its own
    AST_SUB_OVF: assert property (commitNow && aluBus.opClass == cso_pkg::CLS_SUB
        |=> st_reg.flags.v == ($past(st_reg.dst[7]) != $past(st_reg.src[7])
        && st_reg.dst[7] == $past(st_reg.src[7])))
        else $error("subtract overflow wrong");

    AST_TEST_INV_SIGN: assert property (commitNow && aluBus.opClass == cso_pkg::CLS_TEST_INV
        |=> st_reg.flags.s == st_reg.result[7]
        && st_reg.result == (~$past(st_reg.dst) & $past(st_reg.src)))
        else $error("inverted mask test sign or result wrong");

    AST_TEST_SIGN: assert property (commitNow && aluBus.opClass == cso_pkg::CLS_TEST
        |=> st_reg.flags.s == st_reg.result[7]
        && st_reg.result == ($past(st_reg.dst) & $past(st_reg.src)))
        else $error("mask test sign or result wrong");

    // Destination, flags and guard may not drift while the clocks are off
    AST_HALT_RETAIN: assert property (haltedMode |=> $stable(st_reg.dst)
        && $stable(st_reg.flags) && $stable(st_reg.guard))
        else $error("state changed while halted");

    AST_REDIRECT_CAUSE: assert property (pcRedirect |-> $past(commitNow)
        && $past(st_reg.opcode) == `CSO_OP_HALT)
        else $error("redirect without a locked halt");

endmodule

`default_nettype wire

// file: cso_shift_sub_test_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "cso_defs.svh"

module cso_shift_sub_test_bench;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic extIntr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, cpuClkStop, sysClkStop, haltedMode, pcRedirect, busy, errSeen;
    logic [3:0] busyCnt, redirCnt;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;

    cso_shift_sub_test #(.ADDR_W(8)) DUT (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .extIntr(extIntr), .cpuClkStop(cpuClkStop),
        .sysClkStop(sysClkStop), .haltedMode(haltedMode), .pcRedirect(pcRedirect), .busy(busy));

    // 10 MHz clock
    always #50 ref_clk = ~ref_clk;

    // Hang guard, run needs well under 2000 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            close_out();
        end
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Start an opcode; fixed window so a stuck busy cannot hang the run
    task automatic exec(input logic [7:0] op, input logic [3:0] cyc);
        apb(1'b1, `CSO_OFF_CTRL, {23'h0, 1'b1, op});
        busyCnt = 4'h0;
        redirCnt = 4'h0;
        repeat (10) begin
            @(negedge ref_clk);
            busyCnt += {3'h0, busy};
            redirCnt += {3'h0, pcRedirect};
        end
        cmp({28'h0, busyCnt}, {28'h0, cyc});
    endtask

    task automatic rdcmp(input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        cmp(rd, exp);
    endtask

    task automatic t_reset;
        rdcmp(`CSO_OFF_GUARD, 32'h0);
        rdcmp(`CSO_OFF_FLAGS, 32'h0);
        rdcmp(8'h1C, 32'h0);
        cmp({31'h0, errSeen}, 32'h1);
        $display("reset test done");
    endtask

    task automatic t_scf;
        apb(1'b1, `CSO_OFF_FLAGS, 32'h70);
        exec(`CSO_OP_SET_CARRY, 4'h4);
        rdcmp(`CSO_OFF_FLAGS, 32'hF0);
        rdcmp(`CSO_OFF_STATUS, 32'h00004110);
        // Unknown opcode: one cycle, illegal and done sticky, then write-one clear
        exec(8'h00, 4'h1);
        rdcmp(`CSO_OFF_STATUS, 32'h00001118);
        apb(1'b1, `CSO_OFF_STATUS, 32'h1C);
        rdcmp(`CSO_OFF_STATUS, 32'h00001100);
        rdcmp(`CSO_OFF_FLAGS, 32'hF0);
        $display("set carry test done");
    endtask

    task automatic t_sra;
        logic [31:0] tv [2] = '{32'hD09ACD20, 32'hD10100C0};
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, `CSO_OFF_DST, {24'h0, tv[i][23:16]});
            apb(1'b1, `CSO_OFF_FLAGS, 32'h90);
            exec(tv[i][31:24], 4'h4);
            rdcmp(`CSO_OFF_DST, {24'h0, tv[i][15:8]});
            rdcmp(`CSO_OFF_FLAGS, {24'h0, tv[i][7:0]});
            apb(1'b0, `CSO_OFF_STATUS, 32'h0);
            cmp({30'h0, rd[9:8]}, 32'h2);
            cmp({30'h0, rd[6:5]}, (i == 0) ? 32'h1 : 32'h2);
        end
        $display("shift test done");
    endtask

    // Every subtract form, borrow with signed overflow
    task automatic t_sub;
        for (int lo = 2; lo < 7; lo++) begin
            apb(1'b1, `CSO_OFF_DST, 32'h21);
            apb(1'b1, `CSO_OFF_SRC, 32'h90);
            apb(1'b1, `CSO_OFF_FLAGS, 32'h0);
            exec({4'h2, lo[3:0]}, (lo == 2) ? 4'h4 : 4'h6);
            rdcmp(`CSO_OFF_DST, 32'h91);
            rdcmp(`CSO_OFF_SRC, 32'h90);
            rdcmp(`CSO_OFF_FLAGS, 32'hB0);
            apb(1'b0, `CSO_OFF_STATUS, 32'h0);
            cmp({30'h0, rd[9:8]}, (lo < 4) ? 32'h2 : 32'h3);
        end
        $display("subtract test done");
    endtask

    // Entries: opcode, dst, mask, masked result, flags
    task automatic t_test;
        logic [39:0] tv [4] = '{40'h62C70200C0, 40'h662B341480, 40'h722B5400C0, 40'h76C78282A0};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `CSO_OFF_DST, {24'h0, tv[i][31:24]});
            apb(1'b1, `CSO_OFF_SRC, {24'h0, tv[i][23:16]});
            apb(1'b1, `CSO_OFF_FLAGS, 32'h90);
            exec(tv[i][39:32], (tv[i][35:32] == 4'h2) ? 4'h4 : 4'h6);
            rdcmp(`CSO_OFF_RESULT, {24'h0, tv[i][15:8]});
            rdcmp(`CSO_OFF_DST, {24'h0, tv[i][31:24]});
            rdcmp(`CSO_OFF_FLAGS, {24'h0, tv[i][7:0]});
        end
        $display("mask test done");
    endtask

    task automatic t_halt;
        apb(1'b1, `CSO_OFF_FLAGS, 32'h50);
        exec(`CSO_OP_HALT, 4'h4);
        cmp({28'h0, redirCnt}, 32'h1);
        cmp({29'h0, haltedMode, cpuClkStop, sysClkStop}, 32'h0);
        apb(1'b1, `CSO_OFF_GUARD, {24'h0, `CSO_GUARD_UNLOCK});
        exec(`CSO_OP_HALT, 4'h4);
        cmp({28'h0, redirCnt}, 32'h0);
        cmp({29'h0, haltedMode, cpuClkStop, sysClkStop}, 32'h7);
        rdcmp(`CSO_OFF_FLAGS, 32'h50);
        @(posedge ref_clk);
        extIntr <= 1'b1;
        @(posedge ref_clk);
        extIntr <= 1'b0;
        repeat (2) @(negedge ref_clk);
        cmp({29'h0, haltedMode, cpuClkStop, sysClkStop}, 32'h0);
        exec(`CSO_OP_HALT, 4'h4);
        @(posedge ref_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(negedge ref_clk);
        cmp({29'h0, haltedMode, cpuClkStop, sysClkStop}, 32'h0);
        $display("halt test done");
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_reset();
        t_scf();
        t_sra();
        t_sub();
        t_test();
        t_halt();
        close_out();
    end
endmodule

`default_nettype wire
